// ### logic/stp_pkg.sv
// Constants, state types and the pointer-advance function shared by both ends of the
// two-wire target port. Assumes the two ends meet through stp_bus_if.
// Behaviour
// - Target runs at 100k, 400k, 2.5M bit rates
// - Acknowledge and execute only on address match
// - Data changes only while clock low
// - Start and stop frame every transfer
// - Receiver pulls data low to acknowledge
// - Address 0Ch-0Fh, low bits from straps
// - First byte bit 0 selects read/write
// - Second write byte loads register pointer
// - Later write bytes are data, all acknowledged
// - Each further data byte advances pointer
// - Three pointer lines; 03h jumps to 10h
// - Queue mode off: 18h wraps to 00h
// - Queue mode on: 18h wraps to 11h
// - Second line wraps 32h to 30h
// - Third line wraps 62h to 60h
// - Read-only locations acknowledged, never changed
// - Controller ends each write with stop; the bench ends a pointer write before a read with a repeated start
// - Read sends byte, releases, samples acknowledge
// - Controller acknowledge advances pointer, sends next
// - No acknowledge: stop sending, release data
package stp_pkg;

  localparam logic [4:0] TGT_ADDR_HI      = 5'h03;
  localparam logic [3:0] BIT_CNT_BYTE     = 4'h8;
  localparam logic [7:0] PTR_RESET        = 8'h00;
  localparam logic [7:0] LINE0_GAP_LO     = 8'h03;
  localparam logic [7:0] LINE0_GAP_HI     = 8'h10;
  localparam logic [7:0] LINE0_END        = 8'h18;
  localparam logic [7:0] LINE0_WRAP_FLAT  = 8'h00;
  localparam logic [7:0] LINE0_WRAP_QUEUE = 8'h11;
  localparam logic [7:0] LINE1_START      = 8'h30;
  localparam logic [7:0] LINE1_END        = 8'h32;
  localparam logic [7:0] LINE2_START      = 8'h60;
  localparam logic [7:0] LINE2_END        = 8'h62;

  localparam int unsigned CORE_CLK_HZ = 25_000_000;
  localparam int unsigned SCL_STD_HZ  = 100_000;
  localparam int unsigned SCL_FAST_HZ = 400_000;
  localparam int unsigned SCL_HS_HZ   = 2_500_000;
  // Quarter bit periods round up so the bit rate never exceeds its ceiling
  localparam int unsigned QUARTER_STD  = (CORE_CLK_HZ + 4 * SCL_STD_HZ - 1) / (4 * SCL_STD_HZ);
  localparam int unsigned QUARTER_FAST = (CORE_CLK_HZ + 4 * SCL_FAST_HZ - 1) / (4 * SCL_FAST_HZ);
  localparam int unsigned QUARTER_HS   = (CORE_CLK_HZ + 4 * SCL_HS_HZ - 1) / (4 * SCL_HS_HZ);
  localparam int unsigned QCNT_W       = 16;

  typedef enum logic [2:0] {
    TS_IDLE = 3'b000,
    TS_ADDR = 3'b001,
    TS_ACK  = 3'b010,
    TS_RX   = 3'b011,
    TS_TX   = 3'b100,
    TS_ACKR = 3'b101
  } stp_tgt_state_t;

  typedef enum logic [2:0] {
    CS_IDLE  = 3'b000,
    CS_START = 3'b001,
    CS_BIT   = 3'b010,
    CS_STOP  = 3'b011,
    CS_HOLD  = 3'b100
  } stp_ctl_state_t;

  function automatic logic [7:0] stp_next_ptr(input logic [7:0] ptr, input logic queue);
    logic [7:0] nxt;
    nxt = ptr + 8'h01;
    if (ptr == LINE0_GAP_LO) begin
      nxt = LINE0_GAP_HI;
    end else if (ptr == LINE0_END) begin
      nxt = queue ? LINE0_WRAP_QUEUE : LINE0_WRAP_FLAT;
    end else if (ptr == LINE1_END) begin
      nxt = LINE1_START;
    end else if (ptr == LINE2_END) begin
      nxt = LINE2_START;
    end
    return nxt;
  endfunction

endpackage

// ### logic/stp_bus_if.sv
// Two-wire bus between the controller and the target port.
// The data wire is open drain with a pull-up; the clock wire has one driver.
`timescale 1ns/1ps
`default_nettype none
interface stp_bus_if;
  logic scl;
  logic sda_ctl_o;
  logic sda_ctl_oe;
  logic sda_tgt_o;
  logic sda_tgt_oe;
  logic sda;

  // Pull-up wins unless an enabled driver pulls low
  assign sda = (sda_ctl_oe ? sda_ctl_o : 1'b1) & (sda_tgt_oe ? sda_tgt_o : 1'b1);

  modport ctrl (output scl, output sda_ctl_o, output sda_ctl_oe, input sda);
  modport tgt  (input scl, input sda, output sda_tgt_o, output sda_tgt_oe);
endinterface
`default_nettype wire

// ### logic/stp_target.sv
// Target end of the two-wire port: address match, register pointer, byte transfer.
// Runs on its own link-side sampling clock; both bus wires and the straps are pins
// and pass two flops. The register file sits on the user side, same clock.
`timescale 1ns/1ps
`default_nettype none
module stp_target
  import stp_pkg::*;
(
  input  wire logic       link_clk,
  input  wire logic       nrst,
  stp_bus_if.tgt          bus,
  input  wire logic       addr_strap_bit0,
  input  wire logic       addr_strap_bit1,
  input  wire logic       queue_mode,
  output logic [7:0]      reg_addr,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_rd_en,
  input  wire logic       reg_wr_allow,
  output logic            reg_wr_en,
  output logic [7:0]      reg_wr_addr,
  output logic [7:0]      reg_wdata,
  output logic            busy
);
  import stp_pkg::*;

  logic           scl_meta_reg;
  logic           scl_sync_reg;
  logic           scl_prev_reg;
  logic           sda_meta_reg;
  logic           sda_sync_reg;
  logic           sda_prev_reg;
  logic [1:0]     strap_meta_reg;
  logic [1:0]     strap_sync_reg;
  stp_tgt_state_t state_reg;
  logic [3:0]     cnt_reg;
  logic [7:0]     shift_reg;
  logic           read_reg;
  logic           have_ptr_reg;
  logic           mst_ack_reg;
  logic           sda_oe_reg;
  logic [7:0]     ptr_reg;
  logic           rd_en_reg;
  logic           wr_en_reg;
  logic [7:0]     wr_addr_reg;
  logic [7:0]     wdata_reg;
  logic           data_seen_reg;

  logic           start_det;
  logic           stop_det;
  logic           scl_rise;
  logic           scl_fall;
  logic           byte_in_done;
  logic           addr_hit;
  logic           rx_ptr_done;
  logic           rx_data_done;
  logic           load_tx;
  logic           mst_ack_now;
  logic           rx_advance;

  // pin synchronisers
  // At 2.5 MHz a bit still spans over ten link clocks, so two flops plus
  // one edge register leave ample margin on both edges.
  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= bus.scl;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= bus.sda;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      strap_meta_reg <= 2'h0;
      strap_sync_reg <= 2'h0;
    end else begin
      strap_meta_reg <= {addr_strap_bit1, addr_strap_bit0};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  assign start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  assign stop_det  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;
  assign scl_rise  = scl_sync_reg & ~scl_prev_reg;
  assign scl_fall  = ~scl_sync_reg & scl_prev_reg;

  assign addr_hit     = (shift_reg[7:1] == {TGT_ADDR_HI, strap_sync_reg});
  assign byte_in_done = scl_fall && (cnt_reg == BIT_CNT_BYTE);
  assign rx_ptr_done  = (state_reg == TS_RX) && byte_in_done && !have_ptr_reg;
  assign rx_data_done = (state_reg == TS_RX) && byte_in_done && have_ptr_reg;
  assign mst_ack_now  = (state_reg == TS_ACKR) && scl_rise && !sda_sync_reg;
  // A second clock rise proves a real data byte, not a repeated start or stop,
  // so a write pointer only moves once another byte truly follows
  assign rx_advance   = (state_reg == TS_RX) && have_ptr_reg && data_seen_reg &&
                        scl_rise && (cnt_reg == 4'h1);
  assign load_tx      = scl_fall && (((state_reg == TS_ACK) && read_reg) ||
                                     ((state_reg == TS_ACKR) && mst_ack_reg));

  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      state_reg    <= TS_IDLE;
      cnt_reg      <= 4'h0;
      shift_reg    <= 8'h00;
      read_reg     <= 1'b0;
      have_ptr_reg <= 1'b0;
      mst_ack_reg  <= 1'b0;
      sda_oe_reg   <= 1'b0;
    end else if (start_det) begin
      // A repeated start also lands here, abandoning any byte in flight
      state_reg    <= TS_ADDR;
      cnt_reg      <= 4'h0;
      have_ptr_reg <= 1'b0;
      sda_oe_reg   <= 1'b0;
    end else if (stop_det) begin
      state_reg  <= TS_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (load_tx) begin
      state_reg  <= TS_TX;
      cnt_reg    <= 4'h0;
      sda_oe_reg <= ~reg_rdata[7];
      shift_reg  <= {reg_rdata[6:0], 1'b0};
    end else begin
      case (state_reg)
        TS_ADDR, TS_RX: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_sync_reg};
            cnt_reg   <= cnt_reg + 4'h1;
          end else if (byte_in_done) begin
            cnt_reg <= 4'h0;
            if (state_reg == TS_RX || addr_hit) begin
              state_reg  <= TS_ACK;
              sda_oe_reg <= 1'b1;
            end else begin
              state_reg <= TS_IDLE;
            end
            if (state_reg == TS_ADDR) begin
              read_reg <= shift_reg[0];
            end else begin
              have_ptr_reg <= 1'b1;
            end
          end
        end
        TS_ACK: begin
          if (scl_fall) begin
            state_reg  <= TS_RX;
            sda_oe_reg <= 1'b0;
          end
        end
        TS_TX: begin
          if (scl_rise) begin
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (cnt_reg == BIT_CNT_BYTE) begin
              state_reg  <= TS_ACKR;
              sda_oe_reg <= 1'b0;
              cnt_reg    <= 4'h0;
            end else begin
              sda_oe_reg <= ~shift_reg[7];
              shift_reg  <= {shift_reg[6:0], 1'b0};
            end
          end
        end
        TS_ACKR: begin
          if (scl_rise) begin
            mst_ack_reg <= ~sda_sync_reg;
          end else if (scl_fall) begin
            state_reg <= TS_IDLE;
          end
        end
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // pointer survives transfers
  // Only reset and the register-address byte load it, so a read after a
  // repeated start picks up where the write left it.
  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      ptr_reg <= PTR_RESET;
    end else if (rx_ptr_done) begin
      ptr_reg <= shift_reg;
    end else if (rx_advance || mst_ack_now) begin
      ptr_reg <= stp_next_ptr(ptr_reg, queue_mode);
    end
  end

  // Marks that a data byte has landed since the last start
  always_ff @(posedge link_clk) begin
    if (!nrst || start_det) begin
      data_seen_reg <= 1'b0;
    end else if (rx_data_done) begin
      data_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      wr_en_reg   <= 1'b0;
      wr_addr_reg <= 8'h00;
      wdata_reg   <= 8'h00;
      rd_en_reg   <= 1'b0;
    end else begin
      wr_en_reg <= rx_data_done && reg_wr_allow;
      rd_en_reg <= load_tx;
      if (rx_data_done) begin
        wr_addr_reg <= ptr_reg;
        wdata_reg   <= shift_reg;
      end
    end
  end

  assign reg_addr       = ptr_reg;
  assign reg_rd_en      = rd_en_reg;
  assign reg_wr_en      = wr_en_reg;
  assign reg_wr_addr    = wr_addr_reg;
  assign reg_wdata      = wdata_reg;
  assign busy           = (state_reg != TS_IDLE);
  // Open drain: only ever pulls low
  assign bus.sda_tgt_o  = 1'b0;
  assign bus.sda_tgt_oe = sda_oe_reg;

endmodule
`default_nettype wire

// ### logic/stp_ctrl.sv
// Controller end of the two-wire bus: byte-level commands from the user side.
// Makes the bus clock itself by dividing core_clk in quarter bit periods; no
// clock stretching is honoured, the target never holds the clock line.
`timescale 1ns/1ps
`default_nettype none
module stp_ctrl
  import stp_pkg::*;
#(
  parameter int unsigned QUARTER_CYC = QUARTER_STD
)
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  stp_bus_if.ctrl         bus,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_start,
  input  wire logic       cmd_stop,
  input  wire logic       cmd_read,
  input  wire logic       cmd_ack,
  input  wire logic [7:0] cmd_wdata,
  output logic            rsp_valid,
  output logic [7:0]      rsp_rdata,
  output logic            rsp_nack,
  output logic            busy
);
  import stp_pkg::*;

  localparam logic [QCNT_W-1:0] QLAST = QCNT_W'(QUARTER_CYC - 1);

  stp_ctl_state_t    state_reg;
  logic [QCNT_W-1:0] qcnt_reg;
  logic [1:0]        ph_reg;
  logic [3:0]        bit_reg;
  logic [7:0]        shift_reg;
  logic              read_reg;
  logic              ack_reg;
  logic              stop_reg;
  logic              scl_reg;
  logic              sda_oe_reg;
  logic              sda_meta_reg;
  logic              sda_sync_reg;
  logic              rsp_valid_reg;
  logic [7:0]        rsp_rdata_reg;
  logic              rsp_nack_reg;
  logic              tick;
  logic              accept;

  assign cmd_ready = (state_reg == CS_IDLE) || ((state_reg == CS_HOLD) && !scl_reg);
  assign accept    = cmd_valid && cmd_ready;
  assign tick      = (qcnt_reg == QLAST);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
    end else begin
      sda_meta_reg <= bus.sda;
      sda_sync_reg <= sda_meta_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst || accept || tick) begin
      qcnt_reg <= '0;
    end else begin
      qcnt_reg <= qcnt_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_reg     <= CS_IDLE;
      ph_reg        <= 2'h0;
      bit_reg       <= 4'h0;
      shift_reg     <= 8'h00;
      read_reg      <= 1'b0;
      ack_reg       <= 1'b0;
      stop_reg      <= 1'b0;
      scl_reg       <= 1'b1;
      sda_oe_reg    <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_rdata_reg <= 8'h00;
      rsp_nack_reg  <= 1'b0;
    end else begin
      rsp_valid_reg <= 1'b0;
      if (accept) begin
        // idle bus always opens with start
        state_reg <= (cmd_start || state_reg == CS_IDLE) ? CS_START : CS_BIT;
        ph_reg    <= 2'h0;
        bit_reg   <= 4'h0;
        shift_reg <= cmd_read ? 8'hff : cmd_wdata;
        read_reg  <= cmd_read;
        ack_reg   <= cmd_ack;
        stop_reg  <= cmd_stop;
      end else if (tick) begin
        ph_reg <= ph_reg + 2'h1;
        case (state_reg)
          CS_START: begin
            if (ph_reg == 2'h0) sda_oe_reg <= 1'b0;
            if (ph_reg == 2'h1) scl_reg <= 1'b1;
            if (ph_reg == 2'h2) sda_oe_reg <= 1'b1;
            if (ph_reg == 2'h3) state_reg <= CS_BIT;
          end
          CS_BIT: begin
            if (ph_reg == 2'h0) scl_reg <= 1'b0;
            if (ph_reg == 2'h1) begin
              if (bit_reg == BIT_CNT_BYTE) sda_oe_reg <= read_reg && ack_reg;
              else sda_oe_reg <= !read_reg && !shift_reg[7];
            end
            if (ph_reg == 2'h2) scl_reg <= 1'b1;
            if (ph_reg == 2'h3) begin
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == BIT_CNT_BYTE) begin
                rsp_valid_reg <= 1'b1;
                rsp_rdata_reg <= shift_reg;
                rsp_nack_reg  <= sda_sync_reg;
                state_reg     <= stop_reg ? CS_STOP : CS_HOLD;
              end else begin
                shift_reg <= {shift_reg[6:0], sda_sync_reg};
              end
            end
          end
          CS_STOP: begin
            if (ph_reg == 2'h0) scl_reg <= 1'b0;
            if (ph_reg == 2'h1) sda_oe_reg <= 1'b1;
            if (ph_reg == 2'h2) scl_reg <= 1'b1;
            if (ph_reg == 2'h3) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= CS_IDLE;
            end
          end
          CS_HOLD: begin
            // park clock low
            // The target only drops its acknowledge on a falling clock, so a
            // repeated start formed with the clock still high would be lost
            scl_reg <= 1'b0;
            ph_reg  <= 2'h0;
          end
          default: begin
            ph_reg <= 2'h0;
          end
        endcase
      end
    end
  end

  assign rsp_valid      = rsp_valid_reg;
  assign rsp_rdata      = rsp_rdata_reg;
  assign rsp_nack       = rsp_nack_reg;
  assign busy           = (state_reg != CS_IDLE);
  assign bus.scl        = scl_reg;
  assign bus.sda_ctl_o  = 1'b0;
  assign bus.sda_ctl_oe = sda_oe_reg;

endmodule
`default_nettype wire

// ### sim/stp_checker.sv
// Assertions on the two-wire bus wires, sampled on the controller clock.
// Assumes the controller runs with eight core clocks per quarter bit.
`timescale 1ns/1ps
`default_nettype none
module stp_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_ctl_o,
  input wire logic sda_ctl_oe,
  input wire logic sda_tgt_o,
  input wire logic sda_tgt_oe,
  input wire logic sda
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  a_reset_bus_idle: assert property (disable iff (1'b0) !nrst |=> scl && !sda_ctl_oe)
    else $error("bus not idle in reset");
  a_tgt_moves_low: assert property ($changed(sda_tgt_oe) |-> !scl && !$past(scl))
    else $error("target moved data while clock high");
  a_no_contention: assert property (scl |-> !(sda_tgt_oe && sda_ctl_oe))
    else $error("both ends drive data");
  a_open_drain: assert property (!sda_ctl_o && !sda_tgt_o)
    else $error("data driven high");
  a_scl_low_time: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  a_scl_high_time: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  a_start_hold: assert property (scl && $past(scl) && $fell(sda) |-> scl [*4])
    else $error("start not held");
  a_stop_idle: assert property (scl && $past(scl) && $rose(sda) |-> scl [*8] ##1 !sda_tgt_oe)
    else $error("bus not idle after stop");
  c_start: cover property (scl && $past(scl) && $fell(sda));
  c_stop: cover property (scl && $past(scl) && $rose(sda));
  c_tgt_drive: cover property ($rose(sda_tgt_oe));
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Bench joining the controller and target ends over the two-wire bus.
// Assumes a register file kept here, writable only at 30h to 3fh.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import stp_pkg::*;
  typedef struct packed {
    logic [1:0] strap;
    logic       queue;
    logic [7:0] ptr;
    logic [7:0] nxt;
  } stp_row_t;
  localparam logic [3:0] F_START = 4'h8;
  localparam logic [3:0] F_STOP  = 4'h4;
  localparam logic [3:0] F_RD    = 4'h2;
  localparam logic [3:0] F_ACK   = 4'h1;
  logic       core_clk, link_clk, nrst, cmd_valid, cmd_ready, cmd_start, cmd_stop;
  logic       cmd_read, cmd_ack, rsp_valid, rsp_nack, ctl_busy, tgt_busy, queue_mode;
  logic       addr_strap_bit0, addr_strap_bit1, reg_rd_en, reg_wr_allow, reg_wr_en;
  logic [7:0] cmd_wdata, rsp_rdata, reg_addr, reg_rdata, reg_wr_addr, reg_wdata;
  logic [7:0] regs [256];
  int         miscompares, samples_checked, rd_pulses;
  stp_row_t   rows [6];
  stp_bus_if  bus ();
  stp_ctrl #(.QUARTER_CYC(8)) i_stp_ctrl (.core_clk(core_clk), .nrst(nrst), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
    .cmd_read(cmd_read), .cmd_ack(cmd_ack), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack), .busy(ctl_busy));
  stp_target i_stp_target (.link_clk(link_clk), .nrst(nrst), .bus(bus),
    .addr_strap_bit0(addr_strap_bit0), .addr_strap_bit1(addr_strap_bit1),
    .queue_mode(queue_mode), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .reg_rd_en(reg_rd_en), .reg_wr_allow(reg_wr_allow), .reg_wr_en(reg_wr_en),
    .reg_wr_addr(reg_wr_addr), .reg_wdata(reg_wdata), .busy(tgt_busy));
  stp_checker i_stp_checker (.core_clk(core_clk), .nrst(nrst), .scl(bus.scl),
    .sda_ctl_o(bus.sda_ctl_o), .sda_ctl_oe(bus.sda_ctl_oe), .sda_tgt_o(bus.sda_tgt_o),
    .sda_tgt_oe(bus.sda_tgt_oe), .sda(bus.sda));
  function automatic logic writable(input logic [7:0] a);
    return a[7:4] == 4'h3;
  endfunction
  // Read-only contents are a fixed pattern so every address reads distinct
  function automatic logic [7:0] preset(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction
  assign reg_rdata    = regs[reg_addr];
  assign reg_wr_allow = writable(reg_addr);
  always @(posedge link_clk) begin
    if (reg_wr_en === 1'b1) begin
      chk1("write place writable", 1'b1, writable(reg_wr_addr));
      if (writable(reg_wr_addr)) begin
        regs[reg_wr_addr] <= reg_wdata;
      end
    end
  end
  always @(posedge link_clk) begin
    if (reg_rd_en === 1'b1) begin
      rd_pulses++;
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Phase offset keeps the link clock unrelated to the core clock
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  task automatic chk1(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("miscompares %0d, samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Holds the command until taken, then waits for its answer under a bound
  task automatic do_cmd(input logic [3:0] f, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    {cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_ack, cmd_wdata} <= {1'b1, f, d};
    do begin
      @(negedge core_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 1000);
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    if (rsp_valid !== 1'b1) begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic set_ptr(input logic [6:0] a, input logic [7:0] p);
    do_cmd(F_START, {a, 1'b0});
    chk1("write address ack", 1'b0, rsp_nack);
    do_cmd(4'h0, p);
    chk1("pointer ack", 1'b0, rsp_nack);
  endtask
  task automatic rd_open(input logic [6:0] a);
    do_cmd(F_START, {a, 1'b1});
    chk1("read address ack", 1'b0, rsp_nack);
  endtask
  task automatic rd_byte(input logic [3:0] f, input logic [7:0] exp);
    do_cmd(f | F_RD, 8'hff);
    chk8("read byte", exp, rsp_rdata);
  endtask
  initial begin
    {nrst, cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_ack} = 6'h00;
    {addr_strap_bit0, addr_strap_bit1, queue_mode, cmd_wdata} = 11'h000;
    {miscompares, samples_checked} = {32'd0, 32'd0};
    rd_pulses = 0;
    for (int a = 0; a < 256; a++) begin
      regs[a] = preset(8'(a));
    end
    rows = '{'{2'h0, 1'b0, 8'h00, 8'h01}, '{2'h1, 1'b0, 8'h03, 8'h10},
             '{2'h2, 1'b0, 8'h18, 8'h00}, '{2'h3, 1'b1, 8'h18, 8'h11},
             '{2'h1, 1'b0, 8'h32, 8'h30}, '{2'h0, 1'b0, 8'h62, 8'h60}};
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      @(posedge core_clk);
      {addr_strap_bit1, addr_strap_bit0, queue_mode} <= {rows[i].strap, rows[i].queue};
      repeat (4) @(posedge core_clk);
      set_ptr(7'h0c | {5'h00, rows[i].strap}, rows[i].ptr);
      rd_open(7'h0c | {5'h00, rows[i].strap});
      rd_byte(F_ACK, preset(rows[i].ptr));
      rd_byte(F_STOP, preset(rows[i].nxt));
      chk1("target released", 1'b0, bus.sda_tgt_oe);
    end
    do_cmd(F_START | F_STOP, {7'h0d, 1'b0});
    chk1("foreign address ack", 1'b1, rsp_nack);
    set_ptr(7'h0c, 8'h31);
    for (int k = 0; k < 3; k++) begin
      do_cmd(k == 2 ? F_STOP : 4'h0, 8'ha1 + 8'(k));
      chk1("data ack", 1'b0, rsp_nack);
    end
    set_ptr(7'h0c, 8'h30);
    rd_open(7'h0c);
    rd_byte(F_ACK, 8'ha3);
    rd_byte(F_ACK, 8'ha1);
    rd_byte(F_STOP, 8'ha2);
    set_ptr(7'h0c, 8'h10);
    do_cmd(F_STOP, 8'h00);
    chk1("read-only write ack", 1'b0, rsp_nack);
    rd_open(7'h0c);
    rd_byte(F_STOP, preset(8'h10));
    // The stop takes four quarters after the last answer
    for (int w = 0; w < 200 && ctl_busy !== 1'b0; w++) begin
      @(negedge core_clk);
    end
    chk1("controller idle", 1'b0, ctl_busy);
    // Reset while the bus is held mid-transfer
    set_ptr(7'h0c, 8'h12);
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk8("pointer in reset", 8'h00, reg_addr);
    chk1("target busy in reset", 1'b0, tgt_busy);
    chk1("ready in reset", 1'b1, cmd_ready);
    @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd_open(7'h0c);
    rd_byte(F_STOP, preset(8'h00));
    chk8("read strobes", 8'h11, 8'(rd_pulses));
    stop_test();
  end
endmodule
`default_nettype wire
